// file: verilog/pdc_codec.sv
// Protection data type codec: protocol values to and from the word database
`timescale 1ns/1ps
module pdc_codec
    import pdc_pkg::*;
#(
    parameter int DB_WORDS = 1 << DB_AW
)
(
    // Clock and reset
    input  wire logic                REF_CLK,
    input  wire logic                RSTN,
    // Received point from the link side
    input  wire logic                RX_VALID,
    input  wire logic [7:0]          RX_TYPE,
    input  wire logic [15:0]         RX_ADDR,
    input  wire logic [4:0]          RX_COUNT,
    input  wire logic [1:0]          RX_DPI,
    input  wire logic [31:0]         RX_FLOAT,
    input  wire logic [95:0]         RX_IDENT,
    input  wire logic [MEAS_VAL_W*MEAS_MAX_QD9-1:0] RX_MEAS_VAL,
    input  wire logic [MEAS_MAX_QD9-1:0] RX_MEAS_OVF,
    input  wire logic [MEAS_MAX_QD9-1:0] RX_MEAS_INV,
    // General command request
    input  wire logic                CMD_REQ,
    input  wire logic [15:0]         CMD_BIT_ADDR,
    input  wire logic                CMD_OVR_EN,
    input  wire logic [1:0]          CMD_OVR_DPI,
    // Host database port
    input  wire logic                HOST_WE,
    input  wire logic [DB_AW-1:0]    HOST_ADDR,
    input  wire logic [WORD_W-1:0]   HOST_WDATA,
    // Outputs
    output logic      [WORD_W-1:0]   HOST_RDATA,
    output logic                     RX_DONE,
    output logic                     RX_ERR,
    output logic                     CMD_VALID,
    output logic      [1:0]          CMD_DPI,
    output logic                     CMD_ERR
);
    initial
    begin
        if (DB_WORDS < 16 || DB_WORDS > (1 << DB_AW))
            $error("pdc_codec: DB_WORDS out of range");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WRITE = 3'b010,
        ST_DONE  = 3'b100
    } pdc_state_e;

    typedef struct packed {
        pdc_state_e         state;
        logic [4:0]         idx;
        logic [4:0]         cnt;
        logic [7:0]         typ;
        logic [DB_AW-1:0]   base;
        logic [3:0]         bitpos;
        logic               rx_done;
        logic               rx_err;
        logic               cmd_valid;
        logic [1:0]         cmd_dpi;
        logic               cmd_err;
        logic [WORD_W-1:0]  rdata;
    } pdc_regs_s;

    pdc_regs_s r;
    pdc_regs_s next_r;

    logic [WORD_W-1:0] db [DB_WORDS];

    // Capture of the point being stored; held while words are written
    logic [31:0]                         cap_float;
    logic [95:0]                         cap_ident;
    logic [MEAS_VAL_W*MEAS_MAX_QD9-1:0]  cap_val;
    logic [MEAS_MAX_QD9-1:0]             cap_ovf;
    logic [MEAS_MAX_QD9-1:0]             cap_inv;
    logic [1:0]                          cap_dpi;

    // ------------------------------------------------------------
    // Measurand packing, one packer per value
    // ------------------------------------------------------------
    logic [WORD_W-1:0] meas_word [MEAS_MAX_QD9];

    generate
        for (genvar g = 0; g < MEAS_MAX_QD9; g++)
        begin : g_meas
            pdc_meas_pack u_pack (
                .value    (cap_val[g*MEAS_VAL_W +: MEAS_VAL_W]),
                .overflow (cap_ovf[g]),
                .invalid  (cap_inv[g]),
                .word     (meas_word[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Address decoding of a received point
    // ------------------------------------------------------------
    logic               rx_bit_type;
    logic               rx_known;
    logic [4:0]         rx_words;
    logic [DB_AW-1:0]   rx_base;
    logic               rx_count_ok;
    logic [16:0]        rx_dbl;

    always_comb
    begin
        rx_bit_type = 1'b0;
        rx_known    = 1'b1;
        rx_words    = 5'h1;
        rx_count_ok = 1'b1;
        rx_dbl      = {RX_ADDR, 1'b0};
        rx_base     = RX_ADDR[DB_AW-1:0];
        case (RX_TYPE)
            TYPE_TT_STATUS, TYPE_TT_REL:
            begin
                rx_bit_type = 1'b1;
                rx_base     = RX_ADDR[BIT_SHIFT +: DB_AW];
            end
            TYPE_MEAS_QD4:
            begin
                rx_words    = RX_COUNT;
                rx_count_ok = RX_COUNT != 5'h0 && RX_COUNT <= 5'(MEAS_MAX_QD4);
            end
            TYPE_MEAS_QD9:
            begin
                rx_words    = RX_COUNT;
                rx_count_ok = RX_COUNT != 5'h0 && RX_COUNT <= 5'(MEAS_MAX_QD9);
            end
            TYPE_FLOAT_REL:
            begin
                rx_words    = 5'h2;
                rx_base     = rx_dbl[DB_AW-1:0];
            end
            TYPE_IDENT:
            begin
                // Twelve consecutive bytes from the bit address, whole words from its word
                rx_base     = RX_ADDR[BIT_SHIFT +: DB_AW];
                rx_words    = 5'(IDENT_WORDS);
            end
            default:
                rx_known    = 1'b0;
        endcase
    end

    // Command state from two adjacent database bits, or the override
    logic [DB_AW-1:0] cmd_word;
    logic [3:0]       cmd_bit;
    logic [WORD_W:0]  cmd_pair;
    logic [1:0]       cmd_db_dpi;

    always_comb
    begin
        cmd_word   = CMD_BIT_ADDR[BIT_SHIFT +: DB_AW];
        cmd_bit    = CMD_BIT_ADDR[BIT_SHIFT-1:0];
        cmd_pair   = {1'b0, db[cmd_word]} >> cmd_bit;
        cmd_db_dpi = cmd_pair[1:0];
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_r           = r;
        next_r.rx_done   = 1'b0;
        next_r.rx_err    = 1'b0;
        next_r.cmd_valid = 1'b0;
        next_r.cmd_err   = 1'b0;
        next_r.rdata     = db[HOST_ADDR];
        case (r.state)
            ST_IDLE:
            begin
                if (RX_VALID)
                begin
                    if (!rx_known || !rx_count_ok || (rx_bit_type && RX_DPI != DPI_OFF && RX_DPI != DPI_ON))
                        next_r.rx_err = 1'b1;
                    else
                    begin
                        next_r.state  = ST_WRITE;
                        next_r.typ    = RX_TYPE;
                        next_r.base   = rx_base;
                        next_r.bitpos = RX_ADDR[BIT_SHIFT-1:0];
                        next_r.cnt    = rx_words;
                        next_r.idx    = 5'h0;
                    end
                end
            end
            ST_WRITE:
            begin
                if (r.typ == TYPE_TT_STATUS || r.typ == TYPE_TT_REL || r.idx == r.cnt - 5'h1)
                    next_r.state = ST_DONE;
                else
                    next_r.idx = r.idx + 5'h1;
            end
            ST_DONE:
            begin
                next_r.rx_done = 1'b1;
                next_r.state   = ST_IDLE;
            end
            default:
                next_r.state = ST_IDLE;
        endcase
        if (CMD_REQ)
        begin
            next_r.cmd_dpi = CMD_OVR_EN ? CMD_OVR_DPI : cmd_db_dpi;
            next_r.cmd_valid = 1'b1;
            // Unused codes 00 and 11 are refused rather than sent
            next_r.cmd_err = !(next_r.cmd_dpi == DPI_OFF || next_r.cmd_dpi == DPI_ON);
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            r       <= '0;
            r.state <= ST_IDLE;
        end
        else
            r <= next_r;
    end

    // Capture registers sit outside the struct because they are data, not control
    always_ff @(posedge REF_CLK)
    begin
        if (r.state == ST_IDLE && RX_VALID)
        begin
            cap_float <= RX_FLOAT;
            cap_ident <= RX_IDENT;
            cap_val   <= RX_MEAS_VAL;
            cap_ovf   <= RX_MEAS_OVF;
            cap_inv   <= RX_MEAS_INV;
            cap_dpi   <= RX_DPI;
        end
    end

    // ------------------------------------------------------------
    // Database write: link side has priority over the host port
    // ------------------------------------------------------------
    logic [DB_AW-1:0]  wr_addr;
    logic [WORD_W-1:0] wr_data;
    logic [WORD_W-1:0] bit_mask;

    always_comb
    begin
        wr_addr  = r.base + DB_AW'(r.idx);
        wr_data  = meas_word[r.idx[3:0]];
        bit_mask = 16'h0003 << r.bitpos;
        case (r.typ)
            TYPE_TT_STATUS, TYPE_TT_REL:
                wr_data = (db[wr_addr] & ~bit_mask) | (WORD_W'(cap_dpi) << r.bitpos);
            // Low word first in the database; host swaps before use
            TYPE_FLOAT_REL:
                wr_data = r.idx[0] ? cap_float[31:16] : cap_float[15:0];
            // Byte 1 low in word 0; bytes 9..12 are maker bytes kept raw
            TYPE_IDENT:
                wr_data = {cap_ident[r.idx*16+8 +: 8], cap_ident[r.idx*16 +: 8]};
            default:
                wr_data = meas_word[r.idx[3:0]];
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (r.state == ST_WRITE)
            db[wr_addr] <= wr_data;
        else if (HOST_WE)
            db[HOST_ADDR] <= HOST_WDATA;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign HOST_RDATA = r.rdata;
    assign RX_DONE    = r.rx_done;
    assign RX_ERR     = r.rx_err;
    assign CMD_VALID  = r.cmd_valid;
    assign CMD_DPI    = r.cmd_dpi;
    assign CMD_ERR    = r.cmd_err;
endmodule // pdc_codec

// file: verilog/pdc_pkg.sv
// Constants and types shared by the protection data type codec
// What this block does
// - Dual-bit status: 01 is Off, 10 is On; 00 and 11 unused
// - Measurand word bit 0 set on overflow, cleared otherwise
// - Measurand word bit 1: 0 valid, 1 invalid
// - Lowest three measurand bits hold status; bit 2 has no meaning
// - Upper thirteen measurand bits hold signed value, twelve magnitude bits
// - Type 3 accepts one to four values per response
// - Type 9 accepts one to nine values, tolerates up to sixteen
// - Type 4 stored as single-precision binary floating point
// - Type 5 stores twelve characters per point in six words
// - First eight identification bytes are text, last four maker bytes
// - Type 20 command state from two adjacent bits unless overridden
// - Bit-oriented types use bit-granular database addresses
// - Types 1 and 2 are time-tagged two-bit points, 2 adds relative time
// - Word address of a bit address is the bit address divided by sixteen
// - Float at double-word address N occupies words 2N and 2N+1
package pdc_pkg;
    // ------------------------------------------------------------
    // Type codes
    // ------------------------------------------------------------
    localparam logic [7:0] TYPE_TT_STATUS  = 8'h01;
    localparam logic [7:0] TYPE_TT_REL     = 8'h02;
    localparam logic [7:0] TYPE_MEAS_QD4   = 8'h03;
    localparam logic [7:0] TYPE_FLOAT_REL  = 8'h04;
    localparam logic [7:0] TYPE_IDENT      = 8'h05;
    localparam logic [7:0] TYPE_MEAS_QD9   = 8'h09;
    localparam logic [7:0] TYPE_GEN_CMD    = 8'h14;
    // ------------------------------------------------------------
    // Dual-bit codes
    // ------------------------------------------------------------
    localparam logic [1:0] DPI_OFF         = 2'h1;
    localparam logic [1:0] DPI_ON          = 2'h2;
    // ------------------------------------------------------------
    // Measurand word layout
    // ------------------------------------------------------------
    localparam int         MEAS_OVF_BIT    = 0;
    localparam int         MEAS_INV_BIT    = 1;
    localparam int         MEAS_RSV_BIT    = 2;
    localparam int         MEAS_VAL_LSB    = 3;
    localparam int         MEAS_VAL_W      = 13;
    localparam int         MEAS_MAX_QD4    = 4;
    localparam int         MEAS_MAX_QD9    = 16;
    // ------------------------------------------------------------
    // Database geometry
    // ------------------------------------------------------------
    localparam int         WORD_W          = 16;
    localparam int         BIT_SHIFT       = 4;
    localparam int         IDENT_WORDS     = 6;
    localparam int         IDENT_TEXT_B    = 8;
    localparam int         DB_AW           = 12;
    localparam logic [15:0] DB_RESET       = 16'h0000;
endpackage

// file: verilog/pdc_meas_pack.sv
// Packs one measurand value with quality descriptor into a database word
`timescale 1ns/1ps
module pdc_meas_pack
    import pdc_pkg::*;
(
    // Value and quality in
    input  wire logic [MEAS_VAL_W-1:0] value,
    input  wire logic                  overflow,
    input  wire logic                  invalid,
    // Packed word out
    output logic      [WORD_W-1:0]     word
);
    always_comb
    begin
        word                             = '0;
        word[WORD_W-1:MEAS_VAL_LSB]      = value;
        word[MEAS_OVF_BIT]               = overflow;
        word[MEAS_INV_BIT]               = invalid;
        word[MEAS_RSV_BIT]               = 1'b0;
    end
endmodule // pdc_meas_pack

// file: bench/pdc_codec_properties.sv
// Port assertions for the protection data type codec
`timescale 1ns/1ps
module pdc_codec_properties
(
    // Clock and reset
    input wire logic       REF_CLK,
    input wire logic       RSTN,
    // Link side
    input wire logic       RX_VALID,
    input wire logic [7:0] RX_TYPE,
    input wire logic [4:0] RX_COUNT,
    input wire logic [1:0] RX_DPI,
    input wire logic       RX_DONE,
    input wire logic       RX_ERR,
    // Command side
    input wire logic       CMD_REQ,
    input wire logic       CMD_OVR_EN,
    input wire logic [1:0] CMD_OVR_DPI,
    input wire logic       CMD_VALID,
    input wire logic [1:0] CMD_DPI,
    input wire logic       CMD_ERR
);
    // Busy between take and answer, since offers while busy are dropped
    logic busy;
    logic take;
    assign take = RX_VALID && !busy;
    always_ff @(posedge REF_CLK or negedge RSTN)
        if (!RSTN)
            busy <= 1'b0;
        else
            busy <= (busy || take) && !(RX_DONE || RX_ERR);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    sequence s_stored3;
        !RX_DONE ##1 !RX_DONE ##1 RX_DONE;
    endsequence
    // Two-word float: two write cycles, then the done cycle
    sequence s_stored4;
        !RX_DONE ##1 !RX_DONE ##1 !RX_DONE ##1 RX_DONE;
    endsequence
    sequence s_take_status;
        take && RX_TYPE inside {8'h01, 8'h02};
    endsequence
    a_status_walk: assert property (
        s_take_status ##0 RX_DPI inside {2'h1, 2'h2} |=> s_stored3) else $error("status timing");
    a_bad_dpi: assert property (
        s_take_status ##0 RX_DPI inside {2'h0, 2'h3} |=> RX_ERR) else $error("bad status kept");
    a_float_walk: assert property (
        take && RX_TYPE == 8'h04 |=> s_stored4) else $error("float timing");
    a_bad_type: assert property (
        take && !(RX_TYPE inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h09}) |=> RX_ERR)
        else $error("bad type kept");
    a_count_short: assert property (
        take && RX_TYPE == 8'h03 && !(RX_COUNT inside {[1:4]}) |=> RX_ERR) else $error("count 3");
    a_count_long: assert property (
        take && RX_TYPE == 8'h09 && !(RX_COUNT inside {[1:16]}) |=> RX_ERR) else $error("count 9");
    a_cmd_answer: assert property (
        CMD_REQ |=> CMD_VALID) else $error("no command answer");
    a_cmd_override: assert property (
        CMD_REQ && CMD_OVR_EN |=> CMD_DPI == $past(CMD_OVR_DPI)) else $error("override lost");
    a_cmd_code: assert property (
        CMD_VALID |-> CMD_ERR == (CMD_DPI inside {2'h0, 2'h3})) else $error("command code");
endmodule // pdc_codec_properties

bind pdc_codec pdc_codec_properties pdc_codec_properties_i (.REF_CLK(REF_CLK), .RSTN(RSTN),
    .RX_VALID(RX_VALID), .RX_TYPE(RX_TYPE), .RX_COUNT(RX_COUNT), .RX_DPI(RX_DPI),
    .RX_DONE(RX_DONE), .RX_ERR(RX_ERR), .CMD_REQ(CMD_REQ), .CMD_OVR_EN(CMD_OVR_EN),
    .CMD_OVR_DPI(CMD_OVR_DPI), .CMD_VALID(CMD_VALID), .CMD_DPI(CMD_DPI), .CMD_ERR(CMD_ERR));

// file: bench/pdc_slave_model.sv
// Slave device model offering received points to the codec
`timescale 1ns/1ps
module pdc_slave_model
(
    // Clock and answer
    input  wire logic          clk,
    input  wire logic          done,
    input  wire logic          err,
    // Offered point, all fields in one vector
    output logic               valid,
    output logic [398:0]       point
);
    initial valid = 1'b0;
    initial point = '0;
    task automatic send(input logic [398:0] p);
        @(posedge clk);
        #1;
        valid = 1'b1;
        point = p;
        @(posedge clk);
        #1;
        valid = 1'b0;
        repeat (40)
        begin
            @(posedge clk);
            if (done || err)
                break;
        end
        #1;
        // Released payload is inverted so stale use of it shows up
        point = ~p;
    endtask
endmodule // pdc_slave_model

// file: bench/pdc_codec_tb.sv
// Self-checking bench for the protection data type codec
`timescale 1ns/1ps
module pdc_codec_tb
    import pdc_pkg::*;
;
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic              req = 1'b0;
    logic              ovr = 1'b0;
    logic [1:0]        ovd = 2'h0;
    logic [15:0]       cba = 16'h0;
    logic              we = 1'b0;
    logic [DB_AW-1:0]  ha = '0;
    logic [15:0]       hw = 16'h0;
    logic              rv = 1'b0;
    logic              rd_d = 1'b0;
    logic              valid, done, err, cv, ce;
    logic [1:0]        cd;
    logic [15:0]       hr, ov, iv;
    logic [398:0]      pt;
    logic [31:0]       seed = 32'h6379d033;
    logic [31:0]       flt;
    logic [95:0]       idn;
    logic [207:0]      mv;
    logic [15:0]       q_rd[$];
    logic [1:0]        q_rx[$];
    logic [2:0]        q_cmd[$];
    int                fails = 0;
    int                tests_run = 0;
    pdc_slave_model pdc_slave_model_i (.clk(clk), .done(done), .err(err), .valid(valid), .point(pt));
    pdc_codec pdc_codec_i (.REF_CLK(clk), .RSTN(rstn), .RX_VALID(valid), .RX_TYPE(pt[398:391]),
        .RX_ADDR(pt[390:375]), .RX_COUNT(pt[374:370]), .RX_DPI(pt[369:368]), .RX_FLOAT(pt[367:336]),
        .RX_IDENT(pt[335:240]), .RX_MEAS_VAL(pt[239:32]), .RX_MEAS_OVF(pt[31:16]), .RX_MEAS_INV(pt[15:0]),
        .CMD_REQ(req), .CMD_BIT_ADDR(cba), .CMD_OVR_EN(ovr), .CMD_OVR_DPI(ovd), .HOST_WE(we),
        .HOST_ADDR(ha), .HOST_WDATA(hw), .HOST_RDATA(hr), .RX_DONE(done), .RX_ERR(err),
        .CMD_VALID(cv), .CMD_DPI(cd), .CMD_ERR(ce));
    always #25 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic fill();
        flt = rnd();
        idn = {rnd(), rnd(), rnd()};
        mv = 208'({rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()});
        {ov, iv} = rnd();
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic host(input int a, input logic w, input logic [15:0] d);
        @(posedge clk);
        #1;
        ha = a[DB_AW-1:0];
        we = w;
        hw = d;
        rv = !w;
        if (!w)
            q_rd.push_back(d);
        @(posedge clk);
        #1;
        we = 1'b0;
        rv = 1'b0;
    endtask
    task automatic snd(input logic [7:0] t, input int a, input int n, input logic [1:0] d, input logic [1:0] ans);
        q_rx.push_back(ans);
        pdc_slave_model_i.send({t, a[15:0], n[4:0], d, flt, idn, mv, ov, iv});
    endtask
    task automatic cmd(input int a, input logic en, input logic [1:0] v, input logic [2:0] exp);
        @(posedge clk);
        #1;
        req = 1'b1;
        cba = a[15:0];
        ovr = en;
        ovd = v;
        q_cmd.push_back(exp);
        @(posedge clk);
        #1;
        req = 1'b0;
    endtask
    // ----------------------------------------
    // Result watcher: oldest note against each answer
    // ----------------------------------------
    always @(posedge clk)
    begin
        rd_d <= rv;
        if (rd_d)
            chk("host read", q_rd.pop_front(), hr);
        if (done || err)
            chk("rx answer", {14'h0, q_rx.pop_front()}, {14'h0, err, done});
        if (cv)
            chk("command", {13'h0, q_cmd.pop_front()}, {13'h0, ce, cd});
    end
    initial
    begin
        #(3000 * 50);
        fails++;
        stop_test();
    end
    initial
    begin
        fill();
        repeat (20) @(posedge clk);
        #1;
        rstn = 1'b1;
        host(10, 1'b1, 16'h8000);
        host(20, 1'b1, 16'h000c);
        host(54, 1'b1, 16'ha5a5);
        snd(TYPE_TT_STATUS, 160, 0, DPI_OFF, 2'b01);
        snd(TYPE_TT_REL, 163, 0, DPI_ON, 2'b01);
        snd(TYPE_TT_STATUS, 165, 0, 2'b00, 2'b10);
        snd(TYPE_TT_REL, 165, 0, 2'b11, 2'b10);
        host(10, 1'b0, 16'h8011);
        foreach (seed[k])
            if (k < 4)
                snd(k[1] ? (k[0] ? 8'hff : 8'h14) : {7'h0, k[0]} ^ 8'h07, 0, 1, 2'b01, 2'b10);
        snd(TYPE_MEAS_QD4, 50, 0, 2'b00, 2'b10);
        snd(TYPE_MEAS_QD4, 50, 5, 2'b00, 2'b10);
        snd(TYPE_MEAS_QD9, 60, 17, 2'b00, 2'b10);
        snd(TYPE_MEAS_QD4, 50, 4, 2'b00, 2'b01);
        for (int k = 0; k < 4; k++)
            host(50 + k, 1'b0, {mv[13*k +: 13], 1'b0, iv[k], ov[k]});
        host(54, 1'b0, 16'ha5a5);
        fill();
        snd(TYPE_MEAS_QD9, 100, 16, 2'b00, 2'b01);
        for (int k = 0; k < 16; k++)
            host(100 + k, 1'b0, {mv[13*k +: 13], 1'b0, iv[k], ov[k]});
        snd(TYPE_FLOAT_REL, 100, 0, 2'b00, 2'b01);
        host(200, 1'b0, flt[15:0]);
        host(201, 1'b0, flt[31:16]);
        snd(TYPE_IDENT, 1440, 0, 2'b00, 2'b01);
        for (int k = 0; k < 6; k++)
            host(90 + k, 1'b0, idn[16*k +: 16]);
        cmd(160, 1'b0, 2'b00, {1'b0, DPI_OFF});
        cmd(163, 1'b0, 2'b00, {1'b0, DPI_ON});
        cmd(322, 1'b0, 2'b00, 3'b111);
        for (int k = 0; k < 4; k++)
            cmd(160, 1'b1, k[1:0], {k == 0 || k == 3, k[1:0]});
        repeat (5) @(posedge clk);
        if (q_rd.size() + q_rx.size() + q_cmd.size() != 0)
            fails++;
        stop_test();
    end
endmodule // pdc_codec_tb
